// ==== sct_pkg.sv ====
// shared constants and types for the scanner test-switching core
package sct_pkg;

   // core clock rate
   localparam int unsigned CLK_HZ           = 50_000_000;
   localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;

   // scanner response time, nominal and upper limit, in milliseconds
   localparam int unsigned RESP_TIME_MS     = 200;
   localparam int unsigned RESP_TIME_MAX_MS = 400;

   // the same times as clock cycles
   localparam int unsigned RESP_CYC_DEF     = RESP_TIME_MS * CYC_PER_MS;
   localparam int unsigned RESP_CYC_MAX     = RESP_TIME_MAX_MS * CYC_PER_MS;

   // response timer width, enough for the upper limit
   localparam int unsigned TMR_W            = 25;

   // test step as seen on the control pair {ctrl_b, ctrl_a}
   typedef enum logic [1:0] {
      STEP1 = 2'h0,
      STEP2 = 2'h1,
      STEP3 = 2'h2,
      STEP4 = 2'h3
   } sct_step_t;

   // step applied after reset
   localparam sct_step_t STEP_RST = STEP1;

   // reply sequencer
   typedef enum logic {
      ST_IDLE = 1'h0,
      ST_WAIT = 1'h1
   } sct_state_t;

endpackage : sct_pkg

// ==== sct_timer.sv ====
// one-shot down counter that pulses when its load value has run out
`timescale 1ns/1ns
module sct_timer #(
   parameter int unsigned WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             start,
   input  wire logic [WIDTH-1:0] load,
   output logic                  done
);

   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic             done;
   } sct_tmr_t;

   sct_tmr_t cur_q;
   sct_tmr_t nxt_d;

   // a fresh start always restarts the count and cancels a pending pulse
   always_comb begin
      nxt_d      = cur_q;
      nxt_d.done = 1'b0;
      if (start) begin
         nxt_d.cnt = load;
      end else if (cur_q.cnt != '0) begin
         nxt_d.cnt  = cur_q.cnt - WIDTH'(1);
         nxt_d.done = (cur_q.cnt == WIDTH'(1));
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur_q <= '0;
      end else begin
         cur_q <= nxt_d;
      end
   end

   assign done = cur_q.done;

endmodule : sct_timer

// ==== sct_test_switch.sv ====
// scanner-side switching of field states onto three outputs under the test-step pair
`timescale 1ns/1ns
module sct_test_switch #(
   // response time in clock cycles; shorten for simulation
   parameter int unsigned RESP_CYCLES = sct_pkg::RESP_CYC_DEF
) (
   input  wire logic       CORE_CLK,
   input  wire logic       RST,
   input  wire logic       CTRL_A,
   input  wire logic       CTRL_B,
   input  wire logic       FIELD1_CLEAR,
   input  wire logic       FIELD2_CLEAR,
   input  wire logic       TEST_SEEN,
   input  wire logic       CONTAMINATION_WARNING,
   output logic            SW_OUT_1,
   output logic            SW_OUT_2,
   output logic            SW_OUT_3,
   output logic [1:0]      STEP_ACTIVE,
   output logic            REPLY_PENDING
);

   // effective response time, held to the fixed package ceiling RESP_CYC_MAX and at least one cycle
   // clamped response time
   localparam int unsigned RESP_CLAMP = (RESP_CYCLES > sct_pkg::RESP_CYC_MAX) ? sct_pkg::RESP_CYC_MAX :
                                        (RESP_CYCLES == 0) ? 1 : RESP_CYCLES;
   localparam logic [sct_pkg::TMR_W-1:0] RESP_LOAD = sct_pkg::TMR_W'(RESP_CLAMP);

   typedef struct packed {
      sct_pkg::sct_state_t st;
      sct_pkg::sct_step_t  step;
      sct_pkg::sct_step_t  pend;
      logic                sw1;
      logic                sw2;
      logic                sw3;
   } sct_core_t;

   sct_core_t           cur_q;
   sct_core_t           nxt_d;
   sct_pkg::sct_step_t  cmd;
   logic                cmd_new;
   logic                tmr_done;

   // outputs are on (high) when the routed field is clear or detected
   function automatic logic [2:0] sct_route(input sct_pkg::sct_step_t step,
                                            input logic f1, input logic f2,
                                            input logic tst, input logic clean);
      logic [2:0] r;
      r = 3'h0;
      case (step)
         // warning only reaches the third output in step 1
         sct_pkg::STEP1: r = {f1, f2, clean};
         sct_pkg::STEP2: r = {f1, f2, tst};
         sct_pkg::STEP3: r = {tst, f1, f2};
         sct_pkg::STEP4: r = {f2, tst, f1};
         default:        r = 3'h0;
      endcase
      return r;
   endfunction : sct_route

   // the control pair as a step code, b is the high bit
   assign cmd     = sct_pkg::sct_step_t'({CTRL_B, CTRL_A});
   assign cmd_new = (cmd != cur_q.pend);

   // response timer, restarted by every new command
   sct_timer #(
      .WIDTH (sct_pkg::TMR_W)
   ) u_resp_tmr (
      .clk   (CORE_CLK),
      .rst   (RST),
      .start (cmd_new),
      .load  (RESP_LOAD),
      .done  (tmr_done)
   );

   // step sequencer and output routing; a command that changes again
   // mid-wait restarts the wait, so only a settled command is answered
   always_comb begin
      nxt_d = cur_q;
      case (cur_q.st)
         sct_pkg::ST_IDLE: begin
            if (cmd_new) begin
               nxt_d.pend = cmd;
               nxt_d.st   = sct_pkg::ST_WAIT;
            end
         end
         sct_pkg::ST_WAIT: begin
            if (cmd_new) begin
               nxt_d.pend = cmd;
            end else if (tmr_done) begin
               // switch only once response time is over
               nxt_d.step = cur_q.pend;
               nxt_d.st   = sct_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_d.st = sct_pkg::ST_IDLE;
         end
      endcase
      {nxt_d.sw1, nxt_d.sw2, nxt_d.sw3} = sct_route(nxt_d.step, FIELD1_CLEAR, FIELD2_CLEAR,
                                                    TEST_SEEN, ~CONTAMINATION_WARNING);
   end

   // all outputs off after reset: the controller sees no clear field yet
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         cur_q.st   <= sct_pkg::ST_IDLE;
         cur_q.step <= sct_pkg::STEP_RST;
         cur_q.pend <= sct_pkg::STEP_RST;
         cur_q.sw1  <= 1'b0;
         cur_q.sw2  <= 1'b0;
         cur_q.sw3  <= 1'b0;
      end else begin
         cur_q <= nxt_d;
      end
   end

   assign SW_OUT_1      = cur_q.sw1;
   assign SW_OUT_2      = cur_q.sw2;
   assign SW_OUT_3      = cur_q.sw3;
   assign STEP_ACTIVE   = cur_q.step;
   assign REPLY_PENDING = (cur_q.st == sct_pkg::ST_WAIT);

   // ---- checks ----
   // cycles since the last new command, saturating; helper for the timing checks
   logic [sct_pkg::TMR_W-1:0] since_q;
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         since_q <= '0;
      end else if (cmd_new) begin
         since_q <= '0;
      end else if (since_q != '1) begin
         since_q <= since_q + sct_pkg::TMR_W'(1);
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   route_step1_a: assert property (
      (nxt_d.step == sct_pkg::STEP1) |=> (SW_OUT_1 == $past(FIELD1_CLEAR)) &&
         (SW_OUT_2 == $past(FIELD2_CLEAR)) && (SW_OUT_3 == !$past(CONTAMINATION_WARNING)))
      else $error("step 1 output set wrong");

   route_step3_a: assert property (
      (nxt_d.step == sct_pkg::STEP3) |=> (SW_OUT_1 == $past(TEST_SEEN)) &&
         (SW_OUT_2 == $past(FIELD1_CLEAR)) && (SW_OUT_3 == $past(FIELD2_CLEAR)))
      else $error("step 3 output set wrong");

   route_step4_a: assert property (
      (STEP_ACTIVE == sct_pkg::STEP4) && $stable(STEP_ACTIVE) |->
         (SW_OUT_1 == $past(FIELD2_CLEAR)) && (SW_OUT_2 == $past(TEST_SEEN)) &&
         (SW_OUT_3 == $past(FIELD1_CLEAR)))
      else $error("step 4 output set wrong");

   reply_delay_a: assert property (
      $changed(STEP_ACTIVE) |-> (since_q >= RESP_LOAD))
      else $error("step changed before response time");

   reply_value_a: assert property (
      $changed(STEP_ACTIVE) |-> (STEP_ACTIVE == $past(cmd)) && !REPLY_PENDING)
      else $error("step changed to wrong command");

   pending_flag_a: assert property (
      cmd_new |=> REPLY_PENDING && (STEP_ACTIVE == $past(STEP_ACTIVE)))
      else $error("new command not held pending");

   // a pending reply never outlasts the clamped response time
   resp_limit_a: assert property (
      REPLY_PENDING |-> (since_q <= RESP_LOAD))
      else $error("reply wait longer than response time");

   step2_cov: cover property (cmd_new && (cmd == sct_pkg::STEP2) ##[1:300] (STEP_ACTIVE == sct_pkg::STEP2));
   step4_cov: cover property ($changed(STEP_ACTIVE) && (STEP_ACTIVE == sct_pkg::STEP4));
   restart_cov: cover property (REPLY_PENDING && cmd_new);

endmodule : sct_test_switch

// ==== sct_ctrl_model.sv ====
// controller model that cycles the test steps and waits for each reply
`timescale 1ns/1ns
module sct_ctrl_model #(
   parameter int unsigned INTERVAL = 16
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       run,
   input  wire logic [1:0] step_seen,
   input  wire logic [2:0] sw_seen,
   output logic            ctrl_a,
   output logic            ctrl_b,
   output logic            safety_output
);
   logic [1:0]  code_q;
   int unsigned cnt_q;
   logic [2:0]  good_q;
   logic        safety_q;
   logic        bits_ok;
   logic        late;
   // warning bit of step 1 is not judged
   // every routed field and test bit must read high
   // reply still missing once the wait has run out
   always_comb begin
      bits_ok = (step_seen == 2'h0) ? (sw_seen[2:1] == 2'h3) : (sw_seen == 3'h7);
      late    = (cnt_q >= INTERVAL) && (step_seen != code_q);
   end
   // one command per interval, interval above response time
   // next code only once the reply shows
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         code_q   <= 2'h0;
         cnt_q    <= 0;
         good_q   <= 3'h0;
         safety_q <= 1'b0;
      end else if (run) begin
         cnt_q <= cnt_q + 1;
         // on only after four clean steps and while all reads good
         if (!bits_ok || late) begin
            good_q <= 3'h0;
         end else if (cnt_q >= INTERVAL && step_seen == code_q && good_q != 3'h4) begin
            good_q <= good_q + 3'h1;
         end
         safety_q <= (good_q == 3'h4) && bits_ok && !late;
         if (cnt_q >= INTERVAL && step_seen == code_q) begin
            code_q <= code_q + 2'h1;
            cnt_q  <= 0;
         end
      end
   end
   // one code drives both lines, so they can never disagree
   assign {ctrl_b, ctrl_a} = code_q;
   assign safety_output    = safety_q;
endmodule : sct_ctrl_model

// ==== scanner_test_cycle_checker_tb.sv ====
// self-checking bench for the scanner test-switching core
`timescale 1ns/1ns
module scanner_test_cycle_checker_tb;
   localparam int unsigned N = 5;
   logic       core_clk, rst, run, f1, f2, tst, warn, tb_a, tb_b, m_a, m_b;
   logic       sw1, sw2, sw3, pend, safe;
   logic [1:0] step, prev;
   int         num_errors, n_checks, k;
   // rows: step code, inputs {f1,f2,test,warn}, expected {sw1,sw2,sw3}
   logic [1:0] r_code [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
   logic [3:0] r_in   [8] = '{4'ha, 4'h5, 4'h9, 4'h6, 4'hc, 4'h3, 4'h9, 4'h6};
   logic [2:0] r_exp  [8] = '{3'h5, 3'h2, 3'h4, 3'h3, 3'h3, 3'h4, 3'h1, 3'h6};

   sct_test_switch #(.RESP_CYCLES(N)) i_dut (
      .CORE_CLK              (core_clk),
      .RST                   (rst),
      .CTRL_A                (run ? m_a : tb_a),
      .CTRL_B                (run ? m_b : tb_b),
      .FIELD1_CLEAR          (f1),
      .FIELD2_CLEAR          (f2),
      .TEST_SEEN             (tst),
      .CONTAMINATION_WARNING (warn),
      .SW_OUT_1              (sw1),
      .SW_OUT_2              (sw2),
      .SW_OUT_3              (sw3),
      .STEP_ACTIVE           (step),
      .REPLY_PENDING         (pend)
   );

   sct_ctrl_model #(.INTERVAL(16)) i_ctrl (
      .clk       (core_clk),
      .rst       (rst),
      .run       (run),
      .step_seen     (step),
      .sw_seen       ({sw1, sw2, sw3}),
      .ctrl_a        (m_a),
      .ctrl_b        (m_b),
      .safety_output (safe)
   );

   task automatic print_verdict();
      if (num_errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   // bounded wait for the model's safety output to reach a level
   task automatic wait_safe(input logic v, input int lim);
      int c;
      c = 0;
      while (safe !== v && c < lim) begin
         @(posedge core_clk);
         #1;
         c++;
      end
      n_checks++;
      if (safe !== v) begin
         num_errors++;
         $display("mismatch at %0t: safety output stuck", $time);
         print_verdict();
      end
   endtask : wait_safe

   // new code must wait exactly N+1 edges after the taking edge, old step held meanwhile
   task automatic send(input logic [1:0] code);
      logic [1:0] old;
      int         cnt;
      old = step;
      cnt = 0;
      {tb_b, tb_a} = code;
      while (step !== code && cnt < 50) begin
         @(posedge core_clk);
         #1;
         cnt++;
         if (step !== code) begin
            check({6'h0, step}, {6'h0, old}, "early step");
            if (cnt >= 2) check({7'h0, pend}, 8'h1, "pending");
         end
      end
      if (cnt == 50) begin
         num_errors++;
         print_verdict();
      end
      check(cnt[7:0], 8'(N + 2), "reply delay");
      check({7'h0, pend}, 8'h0, "pending after");
   endtask : send

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   initial begin
      {rst, run, f1, f2, tst, warn, tb_a, tb_b} = 8'h80;
      num_errors = 0;
      n_checks = 0;
      repeat (8) @(posedge core_clk);
      #1;
      check({2'h0, sw1, sw2, sw3, step, pend}, 8'h0, "reset");
      rst = 1'b0;
      // table pass: step change timing, then routing of each input pattern
      for (k = 0; k < 8; k++) begin
         if (step !== r_code[k]) send(r_code[k]);
         {f1, f2, tst, warn} = r_in[k];
         @(posedge core_clk);
         #1;
         check({5'h0, sw1, sw2, sw3}, {5'h0, r_exp[k]}, "routing");
      end
      // command changed mid-wait: intermediate code never applied, wait restarts
      {tb_b, tb_a} = 2'h1;
      repeat (3) @(posedge core_clk);
      #1;
      send(2'h2);
      // reset in mid-run clears outputs at once
      rst = 1'b1;
      {tb_b, tb_a} = 2'h0;
      #1;
      check({2'h0, sw1, sw2, sw3, step, pend}, 8'h0, "mid reset");
      @(posedge core_clk);
      #1;
      rst = 1'b0;
      // model-driven cycling with all fields clear, two full rounds
      run = 1'b1;
      {f1, f2, tst, warn} = 4'he;
      prev = step;
      k = 0;
      for (int c = 0; c < 400 && k < 8; c++) begin
         @(posedge core_clk);
         #1;
         if (step !== prev) begin
            check({6'h0, step}, {6'h0, prev + 2'h1}, "step order");
            check({5'h0, sw1, sw2, sw3}, 8'h07, "all clear");
            if (k == 0) check({7'h0, safe}, 8'h0, "safe early");
            prev = step;
            k++;
         end
      end
      check(k[7:0], 8'h8, "rounds done");
      check({7'h0, safe}, 8'h1, "safe on");
      // occupied field drops the safety output, recovery needs a clean cycle
      f1 = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      check({7'h0, safe}, 8'h0, "field occupied");
      f1 = 1'b1;
      wait_safe(1'b1, 300);
      tst = 1'b0;
      wait_safe(1'b0, 60);
      print_verdict();
   end
endmodule : scanner_test_cycle_checker_tb
